/* File: phase_shift_sync_mode_logic.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - master sync out: twice switching rate, half duty
// - slave never drives the sync line
// - slave realigns its half cycle on falling sync
// - slave outputs wait for first sync pulse
// - slave keeps running on own oscillator
// - master sync pulses start after enable threshold
// - slave soft-start ramp starts without sync
// - drives: active leg, passive leg, rectifiers
// - both rectifier drives overlap while freewheeling
// - rectifier turn-off advance grows as load current falls
// - same-leg dead time follows load current
// - transformer pulse never below programmed minimum while that minimum is under half a period
// - modes step sync rect, diode, burst
// - light load holds rectifier drives low
// - bursts hold an even pulse count
// - two PWM cycles confirm a ccm/dcm change
// - threshold at ground or rail forces mode
module phase_shift_sync_mode_logic
   import psfb_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int CODE_W = 8
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic sync_line_clk,
   input wire logic master_strap,
   input wire logic enable_pin,
   input wire logic ss_above_pin,
   input wire logic [CNT_W-1:0] timing_resistor_pin,
   input wire logic [CNT_W-1:0] min_on_time_pin,
   input wire logic [CNT_W-1:0] duty_demand,
   input wire logic [CODE_W-1:0] load_current,
   input wire logic [CODE_W-1:0] light_load_threshold_pin,
   output logic sync_line_o,
   output logic sync_line_oe_n,
   output logic ss_ramp_run,
   output logic active_leg_drive_1,
   output logic active_leg_drive_2,
   output logic passive_leg_drive_1,
   output logic passive_leg_drive_2,
   output logic rectifier_drive_1,
   output logic rectifier_drive_2,
   output logic [1:0] light_mode
);
   typedef struct packed {
      logic strap_meta;
      logic strap_sync;
      logic req_meta;
      logic req_sync;
      logic ss_meta;
      logic ss_sync;
      logic tog_meta;
      logic tog_sync;
      logic tog_last;
      logic role_master;
      logic seen_sync;
      run_state_e run;
      logic [CNT_W-1:0] cnt;
      light_mode_e mode;
      logic [1:0] mode_cnt;
      logic parity;
      logic skip;
      logic sync_o;
      logic ss_run;
      logic [5:0] drv;
   } state_s;

   state_s q;
   state_s d;
   logic fall_tog_q;

   function automatic logic [CNT_W-1:0] load_delay(input logic [CNT_W-1:0] base,
                                                   input logic [CODE_W-1:0] load);
      logic [CODE_W-1:0] light;
      light = (~load) >> LOAD_SHIFT;
      return CNT_W'(base + CNT_W'(light));
   endfunction : load_delay

   // link side: one toggle per falling sync edge
   always_ff @(negedge sync_line_clk or negedge reset_n)
   begin
      if (!reset_n)
         fall_tog_q <= RESET_LEVEL;
      else
         fall_tog_q <= ~fall_tog_q;
   end

   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] half;
   logic [CNT_W-1:0] pos;
   logic [CNT_W-1:0] ph;
   logic [CNT_W-1:0] pos2;
   logic [CNT_W-1:0] pos2_s;
   logic [CNT_W-1:0] dt;
   logic [CNT_W-1:0] adv;
   logic [CNT_W-1:0] min_on;
   logic hsel;
   logic hsel2;
   logic fall;
   logic cyc_end;
   logic want_dcm;
   logic burst_req;
   logic thr_gnd;
   logic thr_rail;
   logic [5:0] drv_n;

   always_comb
   begin
      d = q;
      d.strap_meta = master_strap;
      d.strap_sync = q.strap_meta;
      d.req_meta = enable_pin;
      d.req_sync = q.req_meta;
      d.ss_meta = ss_above_pin;
      d.ss_sync = q.ss_meta;
      d.tog_meta = fall_tog_q;
      d.tog_sync = q.tog_meta;
      d.tog_last = q.tog_sync;
      fall = q.tog_sync ^ q.tog_last;
      period = (timing_resistor_pin < CNT_W'(MIN_PERIOD)) ? CNT_W'(MIN_PERIOD)
         : timing_resistor_pin;
      half = period >> 1;
      hsel = q.cnt >= half;
      pos = hsel ? CNT_W'(q.cnt - half) : q.cnt;
      min_on = (min_on_time_pin >= half) ? CNT_W'(half - 1'b1) : min_on_time_pin;
      ph = (duty_demand < min_on) ? min_on : duty_demand;
      if (ph >= half)
         ph = CNT_W'(half - 1'b1);
      pos2 = (q.cnt >= ph) ? CNT_W'(q.cnt - ph) : CNT_W'(q.cnt + period - ph);
      hsel2 = pos2 >= half;
      pos2_s = hsel2 ? CNT_W'(pos2 - half) : pos2;
      dt = load_delay(CNT_W'(DEAD_TIME_BASE), load_current);
      adv = load_delay(CNT_W'(SR_ADVANCE_BASE), load_current);
      want_dcm = load_current < light_load_threshold_pin;
      burst_req = duty_demand < min_on;
      thr_gnd = light_load_threshold_pin == '0;
      thr_rail = light_load_threshold_pin == '1;
      // role is a strap, frozen while the ramp runs
      d.ss_run = q.req_sync;
      if (!q.ss_run && !q.req_sync)
         d.role_master = q.strap_sync;
      // oscillator: free running, slave realigns per falling edge
      cyc_end = 1'b0;
      if (!q.role_master && fall)
      begin
         d.cnt = hsel ? '0 : half;
         cyc_end = hsel;
      end
      else if (q.cnt >= CNT_W'(period - 1'b1))
      begin
         d.cnt = '0;
         cyc_end = 1'b1;
      end
      else
         d.cnt = CNT_W'(q.cnt + 1'b1);
      if (!q.role_master && fall && q.ss_run)
         d.seen_sync = 1'b1;
      else if (!q.ss_run)
         d.seen_sync = 1'b0;
      case (q.run)
         RUN_IDLE:
            if (q.ss_sync)
               d.run = q.role_master ? RUN_ACTIVE : RUN_WAIT_SYNC;
         RUN_WAIT_SYNC:
            if (!q.ss_sync)
               d.run = RUN_IDLE;
            else if (q.seen_sync)
               d.run = RUN_ACTIVE;
         RUN_ACTIVE:
            if (!q.ss_sync)
               d.run = RUN_IDLE;
         default:
            d.run = RUN_IDLE;
      endcase
      // light-load mode selection
      if (thr_gnd)
      begin
         d.mode = MODE_SYNC_RECT;
         d.mode_cnt = '0;
      end
      else if (thr_rail)
      begin
         d.mode = burst_req ? MODE_BURST : MODE_DIODE_RECT;
         d.mode_cnt = '0;
      end
      else if (cyc_end)
      begin
         if (want_dcm != (q.mode != MODE_SYNC_RECT))
         begin
            if (q.mode_cnt == MODE_CONFIRM_CYCLES - 2'h1)
            begin
               d.mode = want_dcm ? MODE_DIODE_RECT : MODE_SYNC_RECT;
               d.mode_cnt = '0;
            end
            else
               d.mode_cnt = q.mode_cnt + 2'h1;
         end
         else
         begin
            d.mode_cnt = '0;
            if (q.mode != MODE_SYNC_RECT)
               d.mode = burst_req ? MODE_BURST : MODE_DIODE_RECT;
         end
      end
      // burst skipping decided at half boundaries on even parity
      if (d.cnt == '0 || d.cnt == half)
      begin
         if (!q.skip)
            d.parity = ~q.parity;
         if (d.parity == 1'b0 || q.skip)
            d.skip = (q.mode == MODE_BURST) && (q.run == RUN_ACTIVE);
      end
      if (q.run != RUN_ACTIVE)
         d.parity = 1'b0;
      // bridge drive assignment
      drv_n[0] = !hsel && pos >= dt;
      drv_n[1] = hsel && pos >= dt;
      drv_n[2] = !hsel2 && pos2_s >= dt;
      drv_n[3] = hsel2 && pos2_s >= dt;
      drv_n[4] = !(hsel && pos < ph) && !(!hsel && CNT_W'(pos + adv) >= half);
      drv_n[5] = !(!hsel && pos < ph) && !(hsel && CNT_W'(pos + adv) >= half);
      if (q.mode != MODE_SYNC_RECT)
         drv_n[5:4] = 2'b00;
      if (q.run != RUN_ACTIVE || q.skip)
         drv_n = '0;
      d.drv = drv_n;
      // a pulse only starts on a half boundary, so no runt pulse after enable
      d.sync_o = q.role_master && q.ss_sync
         && (q.sync_o ? (pos < (half >> 1)) : (pos == '0));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.run <= RUN_IDLE;
         q.mode <= MODE_SYNC_RECT;
      end
      else
         q <= d;
   end

   assign sync_line_o = q.sync_o;
   assign sync_line_oe_n = reset_n ? !q.role_master : RESET_OE_N;
   assign ss_ramp_run = q.ss_run;
   assign active_leg_drive_1 = q.drv[0];
   assign active_leg_drive_2 = q.drv[1];
   assign passive_leg_drive_1 = q.drv[2];
   assign passive_leg_drive_2 = q.drv[3];
   assign rectifier_drive_1 = q.drv[4];
   assign rectifier_drive_2 = q.drv[5];
   assign light_mode = q.mode;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   AST_SLAVE_NO_DRIVE: assert property (!q.role_master |-> sync_line_oe_n)
      else $error("slave enabled sync driver");
   AST_SYNC_LOW_OFF: assert property (!q.ss_sync |=> !sync_line_o)
      else $error("sync high while not enabled");
   AST_SYNC_AFTER_EN: assert property ($rose(sync_line_o) |-> $past(q.ss_sync) && q.role_master)
      else $error("sync pulse before enable");
   AST_SYNC_HALF_START: assert property ($rose(sync_line_o) |-> $past(q.cnt) == '0
      || $past(q.cnt) == ($past(timing_resistor_pin) >> 1))
      else $error("sync pulse not at half start");
   AST_SLAVE_ALIGN: assert property (!q.role_master && fall && !$past(fall)
      && $stable(timing_resistor_pin) && timing_resistor_pin >= MIN_PERIOD
      |=> q.cnt == '0 || q.cnt == (timing_resistor_pin >> 1))
      else $error("slave did not realign on falling sync");
   AST_WAIT_SYNC: assert property (!q.role_master && !q.seen_sync |=> q.drv == '0)
      else $error("slave switched before sync");
   AST_KEEP_RUN: assert property (q.run == RUN_ACTIVE && q.ss_sync |=> q.run == RUN_ACTIVE)
      else $error("active controller stopped");
   AST_RAMP_NO_SYNC: assert property (q.req_sync |=> ss_ramp_run)
      else $error("ramp not started");
   AST_ROLE_FROZEN: assert property (q.ss_run && $past(q.ss_run) |-> $stable(q.role_master))
      else $error("role changed while running");
   AST_RECT_OFF: assert property (q.mode != MODE_SYNC_RECT |=> !rectifier_drive_1
      && !rectifier_drive_2)
      else $error("rectifier drive in light load");
   AST_THR_GND: assert property (thr_gnd |=> q.mode == MODE_SYNC_RECT)
      else $error("grounded threshold left ccm");
   AST_TWO_CYCLES: assert property ($past(q.mode) == MODE_SYNC_RECT
      && q.mode == MODE_DIODE_RECT
      && !$past(thr_rail) |-> $past(q.mode_cnt) == 2'h1 && $past(cyc_end))
      else $error("mode changed without two cycles");
   AST_EVEN_BURST: assert property ($rose(q.skip) |-> $past(d.parity) == 1'b0)
      else $error("burst ended on odd pulse");
   AST_MIN_ON: assert property (min_on_time_pin < half |-> ph >= min_on_time_pin)
      else $error("on time below minimum");

   COV_MASTER_SYNC: cover property (q.role_master && $rose(sync_line_o));
   COV_SLAVE_ACTIVE: cover property (!q.role_master && q.run == RUN_ACTIVE);
   COV_BURST_SKIP: cover property ($rose(q.skip));
   COV_RECT_OVERLAP: cover property (rectifier_drive_1 && rectifier_drive_2);
endmodule : phase_shift_sync_mode_logic

/* File: psfb_pkg.sv */
package psfb_pkg;
   localparam int LOAD_SHIFT = 4;
   localparam logic [15:0] DEAD_TIME_BASE = 16'h0004;
   localparam logic [15:0] SR_ADVANCE_BASE = 16'h0002;
   localparam logic [1:0] MODE_CONFIRM_CYCLES = 2'h2;
   localparam logic [15:0] MIN_PERIOD = 16'h0008;
   localparam logic RESET_LEVEL = 1'b0;
   localparam logic RESET_OE_N = 1'b1;
   typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT_SYNC, RUN_ACTIVE} run_state_e;
   typedef enum logic [1:0] {MODE_SYNC_RECT, MODE_DIODE_RECT, MODE_BURST} light_mode_e;
endpackage : psfb_pkg

/* File: sync_partner.sv */
`timescale 1ns/100ps
module sync_partner
#(
   parameter int HALF_NS = 40
)
(
   input wire logic run,
   output logic sync_out
);
   // far-end master: pulse train while run, parked low otherwise
   initial
   begin
      sync_out = 1'b0;
      #13;
      forever
      begin
         if (run)
         begin
            sync_out = 1'b1;
            #HALF_NS;
            sync_out = 1'b0;
            #HALF_NS;
         end
         else
         begin
            sync_out = 1'b0;
            #HALF_NS;
         end
      end
   end
endmodule : sync_partner

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic sys_clk, reset_n, strap, en, ss_above, run_far, far_sync, sync_o, oe_n, ramp;
   logic a1, a2, p1, p2, r1, r2, drv_prev, sync_prev;
   logic [15:0] period, min_on, duty;
   logic [7:0] load, thr;
   logic [1:0] mode;
   int fail_count, comparisons, drv_edges, sync_hi, sync_edges, both_hi, rect_hi;
   int a2_hi, p1_hi, p2_hi;
   wire logic sync_line = !oe_n ? sync_o : far_sync;
   sync_partner far (.run(run_far), .sync_out(far_sync));
   phase_shift_sync_mode_logic dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .sync_line_clk(sync_line), .master_strap(strap), .enable_pin(en),
      .ss_above_pin(ss_above), .timing_resistor_pin(period), .min_on_time_pin(min_on),
      .duty_demand(duty), .load_current(load), .light_load_threshold_pin(thr),
      .sync_line_o(sync_o), .sync_line_oe_n(oe_n), .ss_ramp_run(ramp),
      .active_leg_drive_1(a1), .active_leg_drive_2(a2), .passive_leg_drive_1(p1),
      .passive_leg_drive_2(p2), .rectifier_drive_1(r1), .rectifier_drive_2(r2),
      .light_mode(mode));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // edge and level counters for the scenarios
   always @(posedge sys_clk)
   begin
      if (a1 === 1'b1 && drv_prev !== 1'b1) drv_edges++;
      if (sync_o === 1'b1 && sync_prev !== 1'b1) sync_edges++;
      if (sync_o === 1'b1) sync_hi++;
      if (r1 === 1'b1 && r2 === 1'b1) both_hi++;
      if (r1 === 1'b1 || r2 === 1'b1) rect_hi++;
      if (a2 === 1'b1) a2_hi++;
      if (p1 === 1'b1) p1_hi++;
      if (p2 === 1'b1) p2_hi++;
      drv_prev <= a1;
      sync_prev <= sync_o;
   end
   task report_and_stop;
      $display("Counts: %0d mismatches, %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wait_cycles(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : wait_cycles
   task do_reset(input logic role);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      strap <= role;
      en <= 1'b0;
      ss_above <= 1'b0;
      thr <= 8'h00;
      wait_cycles(20);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      wait_cycles(4);
   endtask : do_reset
   task master_test;
      int h0, s0, e0, b0, a0, p0, n0;
      do_reset(1'b1);
      @(posedge sys_clk);
      en <= 1'b1;
      wait_cycles(10);
      check(ramp, 1'b1);
      check(sync_o, 1'b0);
      @(posedge sys_clk);
      ss_above <= 1'b1;
      wait_cycles(30);
      check(oe_n, 1'b0);
      h0 = sync_hi;
      s0 = sync_edges;
      e0 = drv_edges;
      b0 = both_hi;
      a0 = a2_hi;
      p0 = p1_hi;
      n0 = p2_hi;
      wait_cycles(200);
      check(sync_hi - h0, 16'h0064);
      check(sync_edges - s0, 16'h0014);
      check(drv_edges - e0, 16'h000a);
      check(both_hi > b0, 1'b1);
      check(a2_hi - a0, 16'h003c);
      check(p1_hi - p0, 16'h003c);
      check(p2_hi - n0, 16'h003c);
      check(mode, 2'h0);
   endtask : master_test
   task mode_test;
      int r0;
      @(posedge sys_clk);
      thr <= 8'h80;
      load <= 8'h10;
      wait_cycles(3);
      check(mode, 2'h0);
      wait_cycles(60);
      check(mode, 2'h1);
      r0 = rect_hi;
      wait_cycles(40);
      check(rect_hi - r0, 16'h0000);
      @(posedge sys_clk);
      duty <= 16'h0001;
      wait_cycles(60);
      check(mode, 2'h2);
      @(posedge sys_clk);
      thr <= 8'h00;
      wait_cycles(3);
      check(mode, 2'h0);
      @(posedge sys_clk);
      thr <= 8'hff;
      load <= 8'hff;
      duty <= 16'h0006;
      wait_cycles(3);
      check(mode, 2'h1);
   endtask : mode_test
   task slave_test;
      int e0;
      do_reset(1'b0);
      @(posedge sys_clk);
      en <= 1'b1;
      ss_above <= 1'b1;
      wait_cycles(10);
      check(ramp, 1'b1);
      e0 = drv_edges;
      wait_cycles(60);
      check(drv_edges - e0, 16'h0000);
      @(posedge sys_clk);
      run_far <= 1'b1;
      wait_cycles(100);
      check(drv_edges > e0, 1'b1);
      check(oe_n, 1'b1);
      @(posedge sys_clk);
      run_far <= 1'b0;
      wait_cycles(20);
      e0 = drv_edges;
      wait_cycles(100);
      check(drv_edges - e0, 16'h0005);
      @(posedge sys_clk);
      strap <= 1'b1;
      wait_cycles(10);
      check(oe_n, 1'b1);
   endtask : slave_test
   initial
   begin
      reset_n = 1'b0;
      strap = 1'b0;
      en = 1'b0;
      ss_above = 1'b0;
      run_far = 1'b0;
      period = 16'h0014;
      min_on = 16'h0004;
      duty = 16'h0006;
      load = 8'hf0;
      thr = 8'h00;
      master_test();
      mode_test();
      slave_test();
      report_and_stop();
   end
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      report_and_stop();
   end
endmodule : testbench
